// ---- logic/byte_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("byte_fifo depth must be a power of two of at least 2");
		end
	endgenerate

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_state_s;

	fifo_state_s q;
	fifo_state_s n;
	logic [WIDTH-1:0] mem [DEPTH];
	logic do_push;
	logic do_pop;

	assign in_ready = (q.cnt != (AW + 1)'(DEPTH));
	assign out_valid = (q.cnt != '0);
	assign out_data = mem[q.rp];

	always_comb begin
		n = q;
		do_push = in_valid && in_ready;
		do_pop = out_valid && out_ready;
		if (do_push) begin
			n.wp = q.wp + 1'b1;
		end
		if (do_pop) begin
			n.rp = q.rp + 1'b1;
		end
		n.cnt = q.cnt + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	always_ff @(posedge clock) begin
		if (do_push) begin
			mem[q.wp] <= in_data;
		end
	end
endmodule
`default_nettype wire

// ---- logic/capture_controller.sv ----
// Function
// - Converter board: right-justify, zero upper bits.
// - Width switches pick 18, 16, 14, 12 bits.
// - Count switches pick 16384, 8192, 4096, 2048.
// - Stop histogram when a bin hits limit.
// - Auxiliary clock is sample clock halved.
// - Serial link 115200 baud, 8N1.
// - Modem handshake lines are ignored.
// - XOFF (13h) pauses returned data.
// - XON (11h) resumes where it paused.
// - Flow control starts in transmit-permitted state.
// - Ready lamp follows a memory address line.
// - Ready lamp lit at start, dark after sending.
// - Pending lamp lit while data awaits sending.
// - Clock lamp follows the selected sample clock.
// - Direct capture records 32768 consecutive samples.
// - Sample clock source selected by board type.
// - Link check answered; needs sample clock.
// - Histogram bin is top 15 bits.
// - Invert sample MSB before forming bin.
// - Read, increment, write back; drop others.
// - Clear all bins before accumulating.
`timescale 1ns/100ps
`default_nettype none
module capture_controller (
	input wire logic clock,
	input wire logic rst,
	input wire logic sample_ready_clock,
	input wire logic alt_sample_clock,
	input wire logic [capture_pkg::SAMPLE_W-1:0] sample_data,
	input wire logic [capture_pkg::SWITCH_W-1:0] configuration_switch_bank,
	input wire logic serial_rx,
	output logic serial_tx,
	output logic rts_out,
	output logic aux_clock_out,
	output logic lamp_ready,
	output logic lamp_pending,
	output logic lamp_clock
);
	typedef struct packed {
		capture_pkg::mode_e st;
		logic sc1;
		logic sc2;
		logic sc3;
		logic [capture_pkg::SAMPLE_W-1:0] d1;
		logic [capture_pkg::SAMPLE_W-1:0] d2;
		logic rx1;
		logic rx2;
		logic [capture_pkg::SWITCH_W-1:0] sw1;
		logic [capture_pkg::SWITCH_W-1:0] sw2;
		logic aux;
		logic [capture_pkg::ADDR_W-1:0] addr;
		logic [1:0] bsel;
		logic sent;
		logic drain;
		logic xon;
		logic rx_busy;
		logic [3:0] rx_n;
		logic [capture_pkg::BAUD_W-1:0] rx_cnt;
		logic [7:0] rx_sh;
		logic tx_busy;
		logic [3:0] tx_n;
		logic [capture_pkg::BAUD_W-1:0] tx_cnt;
		logic [8:0] tx_sh;
		logic tx_line;
		logic lamp_ready;
		logic lamp_pending;
	} ctrl_state_s;

	ctrl_state_s q;
	ctrl_state_s n;
	logic [capture_pkg::SAMPLE_W-1:0] mem [2 ** capture_pkg::ADDR_W];
	logic [capture_pkg::SAMPLE_W-1:0] rdata_ff;
	logic mem_we;
	logic [capture_pkg::SAMPLE_W-1:0] mem_wd;
	logic clk_pin;
	logic clk_edge;
	logic [1:0] width_sel;
	logic [1:0] count_sel;
	logic [capture_pkg::SAMPLE_W-1:0] mask;
	logic [capture_pkg::SAMPLE_W-1:0] aligned;
	logic [capture_pkg::SAMPLE_W-1:0] offset_bin;
	logic [capture_pkg::SAMPLE_W-1:0] stop;
	logic [capture_pkg::SAMPLE_W-1:0] incremented;
	logic [capture_pkg::ADDR_W-1:0] bin;
	logic got;
	logic push_v;
	logic [7:0] push_d;
	logic push_rdy;
	logic pop;
	logic f_valid;
	logic [7:0] f_data;
	logic mem_active;

	// The clock pin is chosen before the synchroniser; a mux ahead of the first
	// flop adds no hazard, and only one source is ever in use.
	assign clk_pin = q.sw2[capture_pkg::SW_BOARD] ? sample_ready_clock : alt_sample_clock;
	assign clk_edge = q.sc2 && !q.sc3;
	assign width_sel = {q.sw2[capture_pkg::SW_WIDTH_HI], q.sw2[capture_pkg::SW_WIDTH_LO]};
	assign count_sel = {q.sw2[capture_pkg::SW_COUNT_HI], q.sw2[capture_pkg::SW_COUNT_LO]};
	assign stop = capture_pkg::STOP_COUNT[count_sel];
	assign incremented = rdata_ff + 1'b1;

	// Receiver boards keep their own MSB-aligned word; only converter boards are
	// trimmed, and their MSB sits at the top of the selected width.
	always_comb begin
		if (q.sw2[capture_pkg::SW_BOARD]) begin
			mask = capture_pkg::WIDTH_MASK[width_sel];
		end else begin
			mask = capture_pkg::WIDTH_MASK[0];
		end
		aligned = q.d2 & mask;
		offset_bin = aligned ^ (mask ^ (mask >> 1));
		if (q.sw2[capture_pkg::SW_BOARD]) begin
			bin = capture_pkg::ADDR_W'(offset_bin >> capture_pkg::BIN_SHIFT[width_sel]);
		end else begin
			bin = capture_pkg::ADDR_W'(offset_bin >> capture_pkg::BIN_SHIFT[0]);
		end
	end

	always_comb begin
		n = q;
		mem_we = 1'b0;
		mem_wd = '0;
		push_v = 1'b0;
		push_d = '0;
		pop = 1'b0;
		got = 1'b0;
		n.sc1 = clk_pin;
		n.sc2 = q.sc1;
		n.sc3 = q.sc2;
		n.d1 = sample_data;
		n.d2 = q.d1;
		n.rx1 = serial_rx;
		n.rx2 = q.rx1;
		n.sw1 = configuration_switch_bank;
		n.sw2 = q.sw1;
		if (clk_edge) begin
			n.aux = !q.aux;
		end

		// Receiver: sample mid-bit, check start and stop.
		if (!q.rx_busy) begin
			if (!q.rx2) begin
				n.rx_busy = 1'b1;
				n.rx_cnt = capture_pkg::HALF_BIT;
				n.rx_n = '0;
			end
		end else if (q.rx_cnt != '0) begin
			n.rx_cnt = q.rx_cnt - 1'b1;
		end else begin
			n.rx_cnt = capture_pkg::BAUD_TOP;
			n.rx_n = q.rx_n + 1'b1;
			if (q.rx_n == '0 && q.rx2) begin
				n.rx_busy = 1'b0;
			end else if (q.rx_n == capture_pkg::UART_LAST_BIT) begin
				n.rx_busy = 1'b0;
				got = q.rx2;
			end else if (q.rx_n != '0) begin
				n.rx_sh = {q.rx2, q.rx_sh[7:1]};
			end
		end
		if (got && q.rx_sh == capture_pkg::XOFF) begin
			n.xon = 1'b0;
		end
		if (got && q.rx_sh == capture_pkg::XON) begin
			n.xon = 1'b1;
		end

		// Transmitter: a character already started always finishes; XOFF only
		// holds back the next one, which stays in the FIFO.
		if (!q.tx_busy) begin
			if (f_valid && q.xon) begin
				pop = 1'b1;
				n.tx_busy = 1'b1;
				n.tx_line = 1'b0;
				n.tx_sh = {1'b1, f_data};
				n.tx_n = '0;
				n.tx_cnt = capture_pkg::BAUD_TOP;
			end
		end else if (q.tx_cnt != '0) begin
			n.tx_cnt = q.tx_cnt - 1'b1;
		end else if (q.tx_n == capture_pkg::UART_LAST_BIT) begin
			n.tx_busy = 1'b0;
		end else begin
			n.tx_line = q.tx_sh[0];
			n.tx_sh = {1'b1, q.tx_sh[8:1]};
			n.tx_n = q.tx_n + 1'b1;
			n.tx_cnt = capture_pkg::BAUD_TOP;
		end

		unique case (q.st)
			capture_pkg::S_IDLE: begin
				if (got && q.rx_sh == capture_pkg::CMD_CAPTURE) begin
					n.st = capture_pkg::S_CAPT;
					n.addr = '0;
					n.sent = 1'b0;
				end else if (got && q.rx_sh == capture_pkg::CMD_HISTOGRAM) begin
					n.st = capture_pkg::S_CLEAR;
					n.addr = '0;
					n.sent = 1'b0;
				end else if (got && q.rx_sh == capture_pkg::CMD_LINK_CHECK) begin
					n.st = capture_pkg::S_LINK;
				end
			end
			capture_pkg::S_LINK: begin
				// No answer goes out until the sample clock has been seen.
				if (clk_edge) begin
					n.st = capture_pkg::S_REPLY;
				end
			end
			capture_pkg::S_REPLY: begin
				push_v = 1'b1;
				push_d = capture_pkg::LINK_REPLY;
				if (push_rdy) begin
					n.st = capture_pkg::S_IDLE;
				end
			end
			capture_pkg::S_CAPT: begin
				if (clk_edge) begin
					mem_we = 1'b1;
					mem_wd = aligned;
					n.addr = q.addr + 1'b1;
					if (&q.addr) begin
						n.st = capture_pkg::S_RD;
					end
				end
			end
			capture_pkg::S_CLEAR: begin
				mem_we = 1'b1;
				n.addr = q.addr + 1'b1;
				if (&q.addr) begin
					n.st = capture_pkg::S_HWAIT;
				end
			end
			capture_pkg::S_HWAIT: begin
				if (clk_edge) begin
					n.addr = bin;
					n.st = capture_pkg::S_HREAD;
				end
			end
			capture_pkg::S_HREAD: begin
				// Edges seen here and in the next state are simply passed over.
				n.st = capture_pkg::S_HINC;
			end
			capture_pkg::S_HINC: begin
				mem_we = 1'b1;
				mem_wd = incremented;
				if (incremented >= stop) begin
					n.addr = '0;
					n.st = capture_pkg::S_RD;
				end else begin
					n.st = capture_pkg::S_HWAIT;
				end
			end
			capture_pkg::S_RD: begin
				n.bsel = '0;
				n.st = capture_pkg::S_PUSH;
			end
			capture_pkg::S_PUSH: begin
				// Each word goes out as three bytes, most significant first,
				// in ascending address order.
				push_v = 1'b1;
				push_d = 8'({6'h00, rdata_ff} >> (8 * (2 - 32'(q.bsel))));
				if (push_rdy) begin
					if (q.bsel == capture_pkg::LAST_BYTE) begin
						n.addr = q.addr + 1'b1;
						if (&q.addr) begin
							n.st = capture_pkg::S_IDLE;
							n.sent = 1'b1;
							n.drain = 1'b1;
						end else begin
							n.st = capture_pkg::S_RD;
						end
					end else begin
						n.bsel = q.bsel + 1'b1;
					end
				end
			end
		endcase

		if (q.drain && !f_valid && !q.tx_busy) begin
			n.drain = 1'b0;
		end
		n.lamp_pending = n.st == capture_pkg::S_RD || n.st == capture_pkg::S_PUSH || n.drain;
		mem_active = !(n.st == capture_pkg::S_IDLE || n.st == capture_pkg::S_LINK
			|| n.st == capture_pkg::S_REPLY);
		if (mem_active) begin
			n.lamp_ready = n.addr[capture_pkg::LAMP_ADDR_BIT];
		end else begin
			n.lamp_ready = !n.sent;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.st <= capture_pkg::S_IDLE;
			q.rx1 <= 1'b1;
			q.rx2 <= 1'b1;
			q.xon <= 1'b1;
			q.tx_line <= 1'b1;
			q.tx_sh <= 9'h1FF;
			q.lamp_ready <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// The sample store has no reset; every run clears or overwrites it first.
	always_ff @(posedge clock) begin
		if (mem_we) begin
			mem[q.addr] <= mem_wd;
		end
		rdata_ff <= mem[q.addr];
	end

	byte_fifo #(
		.WIDTH(8),
		.DEPTH(capture_pkg::FIFO_DEPTH)
	) u_tx_fifo (
		.clock(clock),
		.rst(rst),
		.in_valid(push_v),
		.in_ready(push_rdy),
		.in_data(push_d),
		.out_valid(f_valid),
		.out_ready(pop),
		.out_data(f_data)
	);

	assign serial_tx = q.tx_line;
	// The modem lines take no part in flow control; this one stays at a fixed level.
	assign rts_out = 1'b0;
	assign aux_clock_out = q.aux;
	assign lamp_ready = q.lamp_ready;
	assign lamp_pending = q.lamp_pending;
	// Seen through the synchroniser, so it follows clocks below half the system rate.
	assign lamp_clock = q.sc2;
endmodule
`default_nettype wire

// ---- logic/capture_pkg.sv ----
`default_nettype none
package capture_pkg;
	localparam int CLK_HZ = 125_000_000;
	localparam int BAUD = 115_200;
	localparam int BAUD_DIV = (CLK_HZ + BAUD / 2) / BAUD;
	localparam int BAUD_W = $clog2(BAUD_DIV);
	localparam logic [BAUD_W-1:0] BAUD_TOP = BAUD_W'(BAUD_DIV - 1);
	localparam logic [BAUD_W-1:0] HALF_BIT = BAUD_W'(BAUD_DIV / 2);
	localparam logic [3:0] UART_LAST_BIT = 4'h9;

	localparam logic [7:0] XON = 8'h11;
	localparam logic [7:0] XOFF = 8'h13;
	localparam logic [7:0] CMD_CAPTURE = 8'h43;
	localparam logic [7:0] CMD_HISTOGRAM = 8'h48;
	localparam logic [7:0] CMD_LINK_CHECK = 8'h3F;
	localparam logic [7:0] LINK_REPLY = 8'h21;

	localparam int SAMPLE_W = 18;
	localparam int ADDR_W = 15;
	localparam int SWITCH_W = 5;
	localparam int LAMP_ADDR_BIT = 12;
	localparam int FIFO_DEPTH = 4;
	localparam logic [1:0] LAST_BYTE = 2'h2;

	// Switch positions inside the bank; a switch that is on reads as 1.
	localparam int SW_BOARD = 0;
	localparam int SW_WIDTH_HI = 1;
	localparam int SW_WIDTH_LO = 2;
	localparam int SW_COUNT_HI = 3;
	localparam int SW_COUNT_LO = 4;

	// Indexed by {upper switch, lower switch}: widths 18, 16, 14, 12.
	localparam logic [SAMPLE_W-1:0] WIDTH_MASK [4] = '{18'h3FFFF, 18'h0FFFF, 18'h03FFF, 18'h00FFF};
	localparam int BIN_SHIFT [4] = '{3, 1, 0, 0};
	localparam logic [SAMPLE_W-1:0] STOP_COUNT [4] = '{18'h04000, 18'h02000, 18'h01000, 18'h00800};

	typedef enum logic [3:0] {
		S_IDLE, S_LINK, S_REPLY, S_CAPT, S_CLEAR, S_HWAIT, S_HREAD, S_HINC, S_RD, S_PUSH
	} mode_e;
endpackage
`default_nettype wire

// ---- tb/adc_capture_serial_controller_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_capture_serial_controller_tb;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic ready_clk = 1'b0;
	logic alt_clk = 1'b0;
	logic [capture_pkg::SAMPLE_W-1:0] data = '0;
	logic [capture_pkg::SWITCH_W-1:0] bank = 5'h01;
	wire logic rx;
	logic tx, rts, aux, lamp_rdy, lamp_pend, lamp_clk, a0;
	int n_errors = 0;
	int samples_checked = 0;
	always #4 clock = ~clock;
	capture_controller DUT (.clock(clock), .rst(rst), .sample_ready_clock(ready_clk),
		.alt_sample_clock(alt_clk), .sample_data(data), .configuration_switch_bank(bank),
		.serial_rx(rx), .serial_tx(tx), .rts_out(rts), .aux_clock_out(aux),
		.lamp_ready(lamp_rdy), .lamp_pending(lamp_pend), .lamp_clock(lamp_clk));
	host_uart_model HOST (.clock(clock), .serial_tx(tx), .serial_rx(rx));
	task automatic cmp_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Two system clocks high and two low per sample: a quarter of the system rate, well
	// inside what the synchroniser resolves, and it keeps the long capture run short.
	task automatic pulse(input int n, input bit alt);
		repeat (n) begin
			@(negedge clock);
			{alt_clk, ready_clk} = alt ? 2'h2 : 2'h1;
			repeat (2) @(negedge clock);
			{alt_clk, ready_clk} = 2'h0;
			data = data + 18'h00001;
			@(negedge clock);
		end
		repeat (4) @(negedge clock);
	endtask
	task automatic t_reset();
		cmp_bit(lamp_rdy, 1'b1);
		cmp_bit(lamp_pend, 1'b0);
		cmp_bit(tx, 1'b1);
		cmp_bit(rts, 1'b0);
		cmp_bit(aux, 1'b0);
		$display("test reset done");
	endtask
	task automatic t_clock();
		for (int i = 0; i < 4; i++) begin
			a0 = aux;
			pulse(1, 0);
			cmp_bit(aux, ~a0);
		end
		ready_clk = 1'b1;
		repeat (5) @(negedge clock);
		cmp_bit(lamp_clk, 1'b1);
		ready_clk = 1'b0;
		bank = 5'h00;
		repeat (5) @(negedge clock);
		cmp_bit(lamp_clk, 1'b0);
		a0 = aux;
		pulse(2, 0);
		cmp_bit(aux, a0);
		pulse(1, 1);
		cmp_bit(aux, ~a0);
		bank = 5'h01;
		repeat (5) @(negedge clock);
		$display("test clock done");
	endtask
	task automatic t_link();
		HOST.send_byte(capture_pkg::CMD_LINK_CHECK);
		repeat (12000) @(negedge clock);
		cmp_bit(HOST.rx_q.size() == 0, 1'b1);
		// The reply is queued while paused, so it must wait for the resume character.
		HOST.send_byte(capture_pkg::XOFF);
		pulse(1, 0);
		repeat (11000) @(negedge clock);
		cmp_bit(HOST.rx_q.size() == 0, 1'b1);
		HOST.send_byte(capture_pkg::XON);
		for (int i = 0; i < 12000 && HOST.rx_q.size() == 0; i++)
			@(negedge clock);
		cmp_byte(HOST.rx_q.size() > 0 ? HOST.rx_q[0] : 8'h00, capture_pkg::LINK_REPLY);
		HOST.rx_q.delete();
		$display("test link done");
	endtask
	task automatic t_capture();
		HOST.send_byte(capture_pkg::CMD_CAPTURE);
		repeat (4) @(negedge clock);
		cmp_bit(lamp_rdy, 1'b0);
		pulse(4095, 0);
		cmp_bit(lamp_rdy, 1'b0);
		pulse(1, 0);
		cmp_bit(lamp_rdy, 1'b1);
		cmp_bit(lamp_pend, 1'b0);
		$display("test capture done");
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge clock);
		n_errors++;
		end_of_test();
	end
	initial begin
		repeat (10) @(negedge clock);
		rst = 1'b0;
		repeat (3) @(negedge clock);
		t_reset();
		t_clock();
		t_link();
		t_capture();
		end_of_test();
	end
endmodule
`default_nettype wire

// ---- tb/capture_controller_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module capture_sva (
	input wire logic clock,
	input wire logic rst,
	input wire logic sample_ready_clock,
	input wire logic alt_sample_clock,
	input wire logic [capture_pkg::SAMPLE_W-1:0] sample_data,
	input wire logic [capture_pkg::SWITCH_W-1:0] configuration_switch_bank,
	input wire logic serial_rx,
	input wire logic serial_tx,
	input wire logic rts_out,
	input wire logic aux_clock_out,
	input wire logic lamp_ready,
	input wire logic lamp_pending,
	input wire logic lamp_clock
);
	logic [13:0] frame_ff;
	logic [13:0] low_ff;
	logic sel;
	assign sel = configuration_switch_bank[0] ? sample_ready_clock : alt_sample_clock;
	// Frame position is counted from the start edge, so bit centres can be checked.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			frame_ff <= 14'h0000;
			low_ff <= 14'h0000;
		end else begin
			low_ff <= serial_tx ? 14'h0000 : low_ff + 14'h0001;
			if (frame_ff == 14'h2A61)
				frame_ff <= 14'h0000;
			else if (frame_ff != 14'h0000 || !serial_tx)
				frame_ff <= frame_ff + 14'h0001;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence lamp_rise;
		!lamp_clock ##1 lamp_clock;
	endsequence
	sequence lamp_quiet;
		!lamp_clock [*5];
	endsequence
	chk_rts_quiet: assert property (!rts_out) else $error("rts moved");
	chk_aux_still: assert property (lamp_quiet |-> $stable(aux_clock_out))
		else $error("aux moved without clock");
	chk_lamp_follow: assert property (lamp_rise |-> $past(sel, 2) || $past(sel, 3))
		else $error("lamp rose without clock");
	chk_lamp_dark: assert property (!sel [*5] |-> !lamp_clock)
		else $error("lamp lit without clock");
	chk_ready_reset: assert property ($fell(rst) |-> lamp_ready && !lamp_pending)
		else $error("lamps wrong after reset");
	chk_start_bit: assert property (frame_ff == 14'h021E |-> !serial_tx)
		else $error("start bit wrong");
	chk_stop_bit: assert property (frame_ff == 14'h2843 |-> serial_tx)
		else $error("stop bit wrong");
	chk_bit_length: assert property ($rose(serial_tx) |-> low_ff % capture_pkg::BAUD_DIV == 0)
		else $error("bit length wrong");
	chk_pending_done: assert property ($fell(lamp_pending) |-> serial_tx)
		else $error("pending dropped mid char");
endmodule
bind capture_controller capture_sva SVA (.clock(clock), .rst(rst),
	.sample_ready_clock(sample_ready_clock), .alt_sample_clock(alt_sample_clock),
	.sample_data(sample_data), .configuration_switch_bank(configuration_switch_bank),
	.serial_rx(serial_rx), .serial_tx(serial_tx), .rts_out(rts_out),
	.aux_clock_out(aux_clock_out), .lamp_ready(lamp_ready), .lamp_pending(lamp_pending),
	.lamp_clock(lamp_clock));
`default_nettype wire

// ---- tb/host_uart_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module host_uart_model (
	input wire logic clock,
	input wire logic serial_tx,
	output logic serial_rx
);
	localparam int BIT = capture_pkg::BAUD_DIV;
	logic [7:0] rx_q[$];
	logic [7:0] shift;
	initial serial_rx = 1'b1;
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clock);
			serial_rx = frame[i];
			repeat (BIT - 1) @(negedge clock);
		end
	endtask
	// A character with a bad stop bit is dropped, so the bench sees it as missing.
	always begin
		@(negedge serial_tx);
		repeat (BIT / 2) @(posedge clock);
		if (serial_tx == 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge clock);
				shift[i] = serial_tx;
			end
			repeat (BIT) @(posedge clock);
			if (serial_tx === 1'b1)
				rx_q.push_back(shift);
		end
	end
endmodule
`default_nettype wire
